// ===== src/xma_pkg.sv
// Constants and types for the extended memory operand ALU.
// Assumes a 32-bit APB master and an 8-bit data path.
package xma_pkg;

    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned MEM_DEPTH = 256;

    // APB byte offsets
    localparam logic [7:0] OFS_COMMAND = 8'h00;
    localparam logic [7:0] OFS_ACCUM = 8'h04;
    localparam logic [7:0] OFS_FLAGS = 8'h08;
    localparam logic [7:0] OFS_MEM_ADDR = 8'h0c;
    localparam logic [7:0] OFS_MEM_DATA = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;

    // Command word fields
    localparam int unsigned CMD_OP_LSB = 0;
    localparam int unsigned CMD_BIT_LSB = 4;
    localparam int unsigned CMD_ADDR_LSB = 8;

    // Flag register bit positions
    localparam int unsigned FLG_C = 0;
    localparam int unsigned FLG_AC = 1;
    localparam int unsigned FLG_Z = 2;
    localparam int unsigned FLG_OV = 3;
    localparam int unsigned FLG_SC = 4;

    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [7:0] BCD_LIMIT = 8'h09;
    localparam logic [7:0] BCD_LOW_FIX = 8'h06;
    localparam logic [7:0] BCD_HIGH_FIX = 8'h60;
    localparam logic [3:0] NIBBLE_MAX = 4'hf;

    typedef enum logic [3:0] {
        ext_add_carry_to_accumulator = 4'b0000,
        ext_add_carry_to_memory      = 4'b0001,
        ext_add_to_accumulator       = 4'b0010,
        ext_add_to_memory            = 4'b0011,
        ext_and_to_accumulator       = 4'b0100,
        ext_and_to_memory            = 4'b0101,
        ext_clear_memory             = 4'b0110,
        ext_clear_bit_memory         = 4'b0111,
        ext_invert_memory            = 4'b1000,
        ext_invert_to_accumulator    = 4'b1001,
        ext_bcd_adjust_to_memory     = 4'b1010,
        ext_decrement_memory         = 4'b1011,
        ext_decrement_to_accumulator = 4'b1100,
        ext_increment_memory         = 4'b1101,
        ext_increment_to_accumulator = 4'b1110,
        ext_reserved_op              = 4'b1111
    } xma_op_type;

    typedef struct packed {
        logic signed_compare_flag;
        logic signed_range_error_flag;
        logic zero_flag;
        logic half_carry_flag;
        logic carry_flag;
    } xma_flags_type;

    localparam xma_flags_type FLAGS_RESET = 5'h00;

    typedef struct packed {
        logic [7:0]    value;
        logic          to_acc;
        logic          to_mem;
        logic          legal;
        xma_flags_type flags;
    } xma_result_type;

endpackage

// ===== src/xma_alu.sv
// Extended memory operand ALU with its own data memory and an APB register port.
// Assumes a single 25 MHz clock and an APB master that keeps to the protocol.
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ps

module xma_alu (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr
);
    import xma_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // State

    logic [7:0]     acc_q;
    xma_flags_type  flags_q;
    logic [7:0]     mem_addr_q;
    logic           bad_op_q;
    logic [7:0]     mem [MEM_DEPTH];
    logic [31:0]    prdata_q;
    logic           pready_q;
    logic           pslverr_q;

    logic           setup_phase;
    logic           access_done;
    logic           wr_en;
    logic           mapped;
    logic           exec_en;
    xma_op_type     op;
    logic [2:0]     bit_sel;
    logic [7:0]     op_addr;
    logic [7:0]     operand;
    xma_result_type res;

    assign setup_phase = psel && !penable;
    assign access_done = psel && penable && pready_q;
    assign wr_en = access_done && pwrite && !pslverr_q;
    assign mapped = (paddr == OFS_COMMAND) || (paddr == OFS_ACCUM) || (paddr == OFS_FLAGS)
                 || (paddr == OFS_MEM_ADDR) || (paddr == OFS_MEM_DATA) || (paddr == OFS_STATUS);
    assign exec_en = wr_en && (paddr == OFS_COMMAND);

    assign op = xma_op_type'(pwdata[CMD_OP_LSB +: 4]);
    assign bit_sel = pwdata[CMD_BIT_LSB +: 3];
    // Linear address, so every section is reachable without a bank switch
    assign op_addr = pwdata[CMD_ADDR_LSB +: ADDR_W];
    assign operand = mem[op_addr];

    ////////////////////////////////////////////////////////////////////////
    // Operation

    always_comb begin
        logic [8:0] sum9;
        logic [4:0] low5;
        logic       cin;
        logic       lo_fix;
        logic       hi_fix;
        logic [7:0] fix;
        sum9 = 9'h000;
        low5 = 5'h00;
        cin = 1'b0;
        lo_fix = 1'b0;
        hi_fix = 1'b0;
        fix = 8'h00;
        res.value = 8'h00;
        res.to_acc = 1'b0;
        res.to_mem = 1'b0;
        res.legal = 1'b1;
        res.flags = flags_q;
        unique case (op)
            ext_add_carry_to_accumulator, ext_add_carry_to_memory,
            ext_add_to_accumulator, ext_add_to_memory: begin
                cin = !op[1] && flags_q.carry_flag;
                sum9 = {1'b0, acc_q} + {1'b0, operand} + {8'h00, cin};
                low5 = {1'b0, acc_q[3:0]} + {1'b0, operand[3:0]} + {4'h0, cin};
                res.value = sum9[7:0];
                res.to_acc = !op[0];
                res.to_mem = op[0];
                res.flags.carry_flag = sum9[8];
                res.flags.half_carry_flag = low5[4];
                res.flags.zero_flag = (sum9[7:0] == 8'h00);
                res.flags.signed_range_error_flag = (acc_q[7] == operand[7]) && (sum9[7] != acc_q[7]);
                res.flags.signed_compare_flag = res.flags.signed_range_error_flag ^ sum9[7];
            end
            ext_and_to_accumulator, ext_and_to_memory: begin
                res.value = acc_q & operand;
                res.to_acc = !op[0];
                res.to_mem = op[0];
                res.flags.zero_flag = (res.value == 8'h00);
            end
            ext_clear_memory: begin
                res.value = 8'h00;
                res.to_mem = 1'b1;
            end
            ext_clear_bit_memory: begin
                res.value = operand;
                res.value[bit_sel] = 1'b0;
                res.to_mem = 1'b1;
            end
            ext_invert_memory, ext_invert_to_accumulator: begin
                res.value = ~operand;
                res.to_acc = op[0];
                res.to_mem = !op[0];
                res.flags.zero_flag = (res.value == 8'h00);
            end
            ext_bcd_adjust_to_memory: begin
                lo_fix = (acc_q[3:0] > BCD_LIMIT[3:0]) || flags_q.half_carry_flag;
                hi_fix = (acc_q[7:4] > BCD_LIMIT[3:0]) || flags_q.carry_flag;
                fix = (lo_fix ? BCD_LOW_FIX : 8'h00) | (hi_fix ? BCD_HIGH_FIX : 8'h00);
                sum9 = {1'b0, acc_q} + {1'b0, fix};
                res.value = sum9[7:0];
                res.to_mem = 1'b1;
                // Only carry moves; it chains multi-byte decimal sums
                res.flags.carry_flag = hi_fix || sum9[8];
            end
            ext_decrement_memory, ext_decrement_to_accumulator: begin
                res.value = operand - 8'h01;
                res.to_acc = (op == ext_decrement_to_accumulator);
                res.to_mem = (op == ext_decrement_memory);
                res.flags.zero_flag = (res.value == 8'h00);
            end
            ext_increment_memory, ext_increment_to_accumulator: begin
                res.value = operand + 8'h01;
                res.to_acc = (op == ext_increment_to_accumulator);
                res.to_mem = (op == ext_increment_memory);
                res.flags.zero_flag = (res.value == 8'h00);
            end
            ext_reserved_op: begin
                res.legal = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Accumulator, flags, status

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q <= ACC_RESET;
        end else if (exec_en && res.to_acc) begin
            acc_q <= res.value;
        end else if (wr_en && paddr == OFS_ACCUM) begin
            acc_q <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= FLAGS_RESET;
        end else if (exec_en) begin
            flags_q <= res.flags;
        end else if (wr_en && paddr == OFS_FLAGS) begin
            flags_q <= pwdata[4:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_addr_q <= 8'h00;
        end else if (wr_en && paddr == OFS_MEM_ADDR) begin
            mem_addr_q <= pwdata[7:0];
        end
    end

    // Shows whether the last command carried a reserved code
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bad_op_q <= 1'b0;
        end else if (exec_en) begin
            bad_op_q <= !res.legal;
        end
    end

    // Data memory is not reset; software must initialise it
    always_ff @(posedge pclk) begin
        if (exec_en && res.to_mem) begin
            mem[op_addr] <= res.value;
        end else if (wr_en && paddr == OFS_MEM_DATA) begin
            mem[mem_addr_q] <= pwdata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB answer: one wait-free access cycle, read data captured at setup

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= setup_phase;
            pslverr_q <= setup_phase && !mapped;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup_phase && !pwrite) begin
            unique case (paddr)
                OFS_ACCUM:    prdata_q <= {24'h000000, acc_q};
                OFS_FLAGS:    prdata_q <= {27'h0000000, flags_q};
                OFS_MEM_ADDR: prdata_q <= {24'h000000, mem_addr_q};
                OFS_MEM_DATA: prdata_q <= {24'h000000, mem[mem_addr_q]};
                OFS_STATUS:   prdata_q <= {31'h00000000, bad_op_q};
                default:      prdata_q <= 32'h0000_0000;
            endcase
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

endmodule

// ===== dv/xma_alu_props.sv
// Checker for the register port of the extended memory operand ALU.
// Assumes one pclk domain and a master that keeps to the bus protocol.
`timescale 1ns/1ps
module xma_alu_props (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr
);
    import xma_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence rd_s(logic [7:0] ad);
        pready && !pwrite && paddr == ad;
    endsequence
    ////////////////////////////////////////////////////////////
    a_ready_after_setup: assert property (setup_s ##1 psel && penable |-> pready)
        else $error("no ready in first access cycle");
    a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready longer than one cycle");
    a_ready_in_access: assert property (pready |-> psel && penable) else $error("ready outside access");
    a_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
    a_err_unmapped: assert property (pready && paddr > OFS_STATUS |-> pslverr) else $error("unmapped not refused");
    a_err_mapped: assert property (pready && paddr[1:0] == 2'h0 && paddr <= OFS_STATUS |-> !pslverr)
        else $error("mapped access refused");
    a_acc_width: assert property (rd_s(OFS_ACCUM) |-> prdata[31:8] == 24'h0)
        else $error("accumulator wider than a byte");
    a_mem_width: assert property (rd_s(OFS_MEM_DATA) |-> prdata[31:8] == 24'h0)
        else $error("memory wider than a byte");
    a_flags_width: assert property (rd_s(OFS_FLAGS) |-> prdata[31:5] == 27'h0) else $error("flag spare bits set");
    a_cmd_reads_zero: assert property (rd_s(OFS_COMMAND) |-> prdata == 32'h0) else $error("command reads nonzero");
    a_err_read_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("refused read not zero");
endmodule
bind xma_alu xma_alu_props i_xma_alu_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

// ===== dv/xma_apb_host.sv
// Bus master model standing in for the core that issues extended instructions.
// Assumes xfer is entered right after a rising edge of pclk.
`timescale 1ns/1ps
module xma_apb_host (
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
    end
    // No wait bound here: the bench timeout ends a hung slave
    task automatic xfer(input logic w, input logic [7:0] ad, input logic [31:0] wd,
                        output logic [31:0] rd, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
endmodule

// ===== dv/xma_alu_bench.sv
// Self-checking bench: random and corner extended instructions over the bus.
// Assumes the ALU, its bound checker and the bus master model.
`timescale 1ns/1ps
module xma_alu_bench;
    import xma_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr, e;
    logic [7:0]  paddr, ad, a, m, ea, em;
    logic [31:0] pwdata, prdata, rd;
    logic [4:0]  f, ef;
    logic [3:0]  op;
    logic [2:0]  b;
    int          miscompares = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    int          seed = 9951;
    logic [7:0]  rst_ofs [5] = '{OFS_COMMAND, OFS_ACCUM, OFS_FLAGS, OFS_MEM_ADDR, OFS_STATUS};

    xma_alu i_xma_alu (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    xma_apb_host i_xma_apb_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    initial forever #20 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            stop_test();
        end
    end
    ////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("compares %0d miscompares %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_err(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: error response %b", $time, got);
        end
    endtask
    task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
        i_xma_apb_host.xfer(1'b1, ofs, d, rd, e);
    endtask
    task automatic rdr(input logic [7:0] ofs);
        i_xma_apb_host.xfer(1'b0, ofs, 32'h0, rd, e);
    endtask
    // Expected state after one command; flags are {sc, ov, z, ac, c}
    function automatic void model(input logic [3:0] op, input logic [2:0] b, inout logic [7:0] a,
                                  inout logic [7:0] m, inout logic [4:0] f);
        logic [8:0] s;
        logic [4:0] h;
        logic [7:0] r;
        logic [7:0] fx;
        logic       ov;
        h = {1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, op < 4'h2 && f[0]};
        s = {1'b0, a} + {1'b0, m} + {8'h0, op < 4'h2 && f[0]};
        ov = a[7] == m[7] && s[7] != a[7];
        fx = {(a[7:4] > 4'h9 || f[0]) ? 4'h6 : 4'h0, (a[3:0] > 4'h9 || f[1]) ? 4'h6 : 4'h0};
        r = m;
        case (op)
            4'h0, 4'h1, 4'h2, 4'h3: begin
                r = s[7:0];
                f = {ov ^ r[7], ov, r == 8'h0, h[4], s[8]};
            end
            4'h4, 4'h5: r = a & m;
            4'h6: r = 8'h00;
            4'h7: r = m & ~(8'h01 << b);
            4'h8, 4'h9: r = ~m;
            4'ha: begin
                s = {1'b0, a} + {1'b0, fx};
                r = s[7:0];
                // High correction is 6 in the upper nibble, so bit 6 marks it
                f[0] = fx[6] | s[8];
            end
            4'hb, 4'hc: r = m - 8'h01;
            4'hd, 4'he: r = m + 8'h01;
            default: r = m;
        endcase
        if (op inside {4'h4, 4'h5, 4'h8, 4'h9, [4'hb:4'he]}) f[2] = r == 8'h0;
        if (op inside {4'h0, 4'h2, 4'h4, 4'h9, 4'hc, 4'he}) a = r;
        else if (op != 4'hf) m = r;
    endfunction
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (rst_ofs[k]) begin
            rdr(rst_ofs[k]);
            chk_val(rd, 32'h0, "reset value");
        end
        $display("reset test done");
        wr(8'h18, 32'h5a);
        chk_err(e, 1'b1);
        rdr(8'h18);
        chk_val(rd, 32'h0, "unmapped read");
        chk_err(e, 1'b1);
        $display("unmapped test done");
        for (int i = 0; i < 160; i++) begin
            op = 4'(i);
            ad = 8'($random(seed));
            b = 3'($random(seed));
            a = 8'($random(seed));
            m = 8'($random(seed));
            f = 5'($random(seed));
            // Wrap corners for increment and decrement first
            if (i < 32) m = (i < 16) ? 8'hff : 8'h00;
            wr(OFS_MEM_ADDR, {24'h0, ad});
            wr(OFS_MEM_DATA, {24'h0, m});
            // Pointer moved away so the command must use its own address
            wr(OFS_MEM_ADDR, {24'h0, ~ad});
            wr(OFS_ACCUM, {24'h0, a});
            wr(OFS_FLAGS, {27'h0, f});
            wr(OFS_COMMAND, {16'h0, ad, 1'b0, b, op});
            ea = a;
            em = m;
            ef = f;
            model(op, b, ea, em, ef);
            rdr(OFS_ACCUM);
            chk_val(rd, {24'h0, ea}, "accumulator");
            rdr(OFS_FLAGS);
            chk_val(rd, {27'h0, ef}, "flags");
            wr(OFS_MEM_ADDR, {24'h0, ad});
            rdr(OFS_MEM_DATA);
            chk_val(rd, {24'h0, em}, "memory");
            rdr(OFS_STATUS);
            chk_val(rd, {31'h0, op == 4'hf}, "status");
        end
        $display("command sweep done");
        stop_test();
    end
endmodule
